// [shared/mps_pkg.sv]
package mps_pkg;
    localparam int MPS_SLICE_W = 4;
    localparam int MPS_STACK_DEPTH = 4;
    localparam int MPS_DEPTH_W = 3;
    localparam logic [MPS_SLICE_W-1:0] MPS_ADDR_RST = 4'h0;
    localparam logic [MPS_SLICE_W-1:0] MPS_COUNT_RST = 4'h0;
    localparam logic [MPS_SLICE_W-1:0] MPS_VECTOR_RST = 4'h0;
    localparam logic [MPS_SLICE_W-1:0] MPS_STATUS_RST = 4'h0;
    localparam logic [MPS_DEPTH_W-1:0] MPS_DEPTH_FULL = 3'h4;
    localparam int MPS_BRM_KEEP_LSB = 2;

    typedef enum logic [3:0] {
        OP_INCREMENT,
        OP_JUMP_NEXT,
        OP_JUMP_IBUS,
        OP_JUMP_IBUS_LOAD_VEC,
        OP_JUMP_PRIMARY,
        OP_JUMP_OBUS,
        OP_JUMP_NEXT_LOAD_VEC,
        OP_JUMP_NEXT_SAVE_ADDR,
        OP_CALL,
        OP_RETURN,
        OP_REPEAT_SUB_LOAD,
        OP_REPEAT_CURRENT,
        OP_COND_BRANCH,
        OP_COND_CALL,
        OP_COND_RETURN,
        OP_MULTIWAY
    } mps_op_t;

    typedef enum logic [1:0] {
        OSEL_NONE,
        OSEL_NEXT_FIELD,
        OSEL_STACK_TOP,
        OSEL_STATUS
    } mps_osel_t;

    typedef struct packed {
        logic [MPS_SLICE_W-1:0] load_mask;
        logic [MPS_SLICE_W-1:0] set_mask;
        logic [MPS_SLICE_W-1:0] clear_mask;
    } mps_status_ctl_t;

    typedef struct packed {
        logic use_status;
        logic [1:0] bit_sel;
    } mps_cond_sel_t;
endpackage

// [rtl/mps_sequencer.sv]
`timescale 1ns/1ps
// Overview of operation
// - Four address bits per slice, cascadable
// - Five address buses reach memory and parts
// - Address register drives microprogram memory
// - Repeat counter, also holds return address
// - Vector register holds start address jump target
// - Status bits loaded from tests, testable
// - Microprogram sets or clears status bits
// - Status register doubles as page address
// - Four-word automatic subroutine stack
// - Stack reachable through I and O buses
// - Two branch inputs, true and inverted
// - Sixteen instructions pick next address source
// - Repeat load count, then repeat current word
// - Conditional branch, else increment
// - Conditional return, else jump to field
// - Primary jump takes vector register
// - Next field routed out on O bus
module mps_sequencer
    import mps_pkg::*;
#(
    parameter int W = MPS_SLICE_W
)(
    // Clock and control
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CE,
    // Microprogram instruction fields
    input wire mps_pkg::mps_op_t INSTR,
    input wire logic [W-1:0] NEXT_ADDRESS_FIELD,
    input wire mps_pkg::mps_cond_sel_t COND_SEL,
    input wire mps_pkg::mps_osel_t O_SEL,
    // Branch inputs
    input wire logic BRANCH_COND,
    input wire logic BRANCH_COND_INVERTED_N,
    // Slice cascade
    input wire logic CARRY_IN,
    output logic CARRY_OUT,
    // Microprogram memory address and page
    output logic [W-1:0] MICRO_ADDR,
    output logic [W-1:0] PAGE_ADDR,
    // I bus and O bus
    input wire logic [W-1:0] I_BUS,
    input wire logic [W-1:0] O_BUS_IN,
    output logic [W-1:0] O_BUS_OUT,
    output logic O_BUS_OE,
    // Status test points
    input wire logic [W-1:0] STATUS_TEST_IN,
    input wire mps_pkg::mps_status_ctl_t STATUS_CTL,
    output logic [W-1:0] STATUS_OUT,
    // Stack extension
    input wire logic STACK_EXT_PUSH,
    output logic STACK_FULL,
    output logic [W-1:0] STACK_TOP
);
    import mps_pkg::*;

    logic [W-1:0] micro_address_reg, micro_address_next;
    logic [W-1:0] repeat_count_reg, repeat_count_next;
    logic [W-1:0] instruction_vector_reg, instruction_vector_next;
    logic [W-1:0] status_page_reg, status_page_next;
    logic [W-1:0] stack_reg [MPS_STACK_DEPTH];
    logic [MPS_DEPTH_W-1:0] depth_reg, depth_next;
    logic [W-1:0] o_bus_reg;
    logic o_oe_reg;

    // Lowest slice ties CARRY_IN high so the chain increments by one
    wire [W-1:0] addr_inc = micro_address_reg + {{(W-1){1'b0}}, CARRY_IN};
    wire carry_out_w = CARRY_IN & (&micro_address_reg);
    wire branch_in = BRANCH_COND | ~BRANCH_COND_INVERTED_N;
    wire status_bit = status_page_reg[COND_SEL.bit_sel];
    wire cond = COND_SEL.use_status ? status_bit : branch_in;
    wire repeat_busy = (repeat_count_reg != '0);
    wire [W-1:0] stack_top_w = stack_reg[0];

    function automatic logic [W-1:0] dec_one(input logic [W-1:0] v);
        dec_one = v - {{(W-1){1'b0}}, 1'b1};
    endfunction

    logic do_push, do_pop;
    logic [W-1:0] push_val;

    always_comb
    begin
        micro_address_next = addr_inc;
        repeat_count_next = repeat_count_reg;
        instruction_vector_next = instruction_vector_reg;
        do_push = 1'b0;
        do_pop = 1'b0;
        push_val = addr_inc;
        unique case (INSTR)
            OP_INCREMENT: micro_address_next = addr_inc;
            OP_JUMP_NEXT: micro_address_next = NEXT_ADDRESS_FIELD;
            OP_JUMP_IBUS: micro_address_next = I_BUS;
            OP_JUMP_IBUS_LOAD_VEC:
            begin
                micro_address_next = I_BUS;
                instruction_vector_next = I_BUS;
            end
            OP_JUMP_PRIMARY: micro_address_next = instruction_vector_reg;
            OP_JUMP_OBUS: micro_address_next = O_BUS_IN;
            OP_JUMP_NEXT_LOAD_VEC:
            begin
                micro_address_next = NEXT_ADDRESS_FIELD;
                instruction_vector_next = NEXT_ADDRESS_FIELD;
            end
            OP_JUMP_NEXT_SAVE_ADDR:
            begin
                micro_address_next = NEXT_ADDRESS_FIELD;
                repeat_count_next = addr_inc;
            end
            OP_CALL:
            begin
                micro_address_next = NEXT_ADDRESS_FIELD;
                do_push = 1'b1;
            end
            OP_RETURN:
            begin
                micro_address_next = stack_top_w;
                do_pop = 1'b1;
            end
            OP_REPEAT_SUB_LOAD: repeat_count_next = NEXT_ADDRESS_FIELD;
            OP_REPEAT_CURRENT:
            begin
                // Re-executes while the count is nonzero, then falls through
                if (repeat_busy)
                begin
                    micro_address_next = micro_address_reg;
                    repeat_count_next = dec_one(repeat_count_reg);
                end
            end
            OP_COND_BRANCH:
                micro_address_next = cond ? NEXT_ADDRESS_FIELD : addr_inc;
            OP_COND_CALL:
            begin
                micro_address_next = cond ? NEXT_ADDRESS_FIELD : addr_inc;
                do_push = cond;
            end
            OP_COND_RETURN:
            begin
                micro_address_next = cond ? stack_top_w : NEXT_ADDRESS_FIELD;
                do_pop = cond;
            end
            OP_MULTIWAY:
                micro_address_next = {NEXT_ADDRESS_FIELD[W-1:MPS_BRM_KEEP_LSB],
                                      status_bit, branch_in};
        endcase
        // External push only when the instruction leaves the stack alone
        if (!do_push && !do_pop && STACK_EXT_PUSH)
        begin
            do_push = 1'b1;
            push_val = I_BUS;
        end
    end

    always_comb
    begin
        depth_next = depth_reg;
        if (do_push && depth_reg != MPS_DEPTH_FULL)
            depth_next = depth_reg + 3'h1;
        else if (do_pop && depth_reg != '0)
            depth_next = depth_reg - 3'h1;
    end

    // Set beats clear beats load, so a microprogram flag is never lost
    always_comb
    begin
        status_page_next = (status_page_reg & ~STATUS_CTL.load_mask)
                         | (STATUS_TEST_IN & STATUS_CTL.load_mask);
        status_page_next = (status_page_next & ~STATUS_CTL.clear_mask)
                         | STATUS_CTL.set_mask;
    end

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            micro_address_reg <= MPS_ADDR_RST;
            repeat_count_reg <= MPS_COUNT_RST;
            instruction_vector_reg <= MPS_VECTOR_RST;
            status_page_reg <= MPS_STATUS_RST;
            depth_reg <= '0;
        end
        else if (CE)
        begin
            micro_address_reg <= micro_address_next;
            repeat_count_reg <= repeat_count_next;
            instruction_vector_reg <= instruction_vector_next;
            status_page_reg <= status_page_next;
            depth_reg <= depth_next;
        end
    end

    // Shift stack: the push moves every word down and the bottom word drops out
    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            for (int k = 0; k < MPS_STACK_DEPTH; k++)
                stack_reg[k] <= '0;
        end
        else if (CE && do_push)
        begin
            stack_reg[0] <= push_val;
            for (int k = 1; k < MPS_STACK_DEPTH; k++)
                stack_reg[k] <= stack_reg[k-1];
        end
        else if (CE && do_pop)
        begin
            for (int k = 0; k < MPS_STACK_DEPTH - 1; k++)
                stack_reg[k] <= stack_reg[k+1];
            stack_reg[MPS_STACK_DEPTH-1] <= '0;
        end
    end

    wire [W-1:0] o_bus_sel = (O_SEL == OSEL_NEXT_FIELD) ? NEXT_ADDRESS_FIELD
                           : (O_SEL == OSEL_STACK_TOP) ? stack_top_w
                           : (O_SEL == OSEL_STATUS) ? status_page_reg
                           : '0;

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            o_bus_reg <= '0;
            o_oe_reg <= 1'b0;
        end
        else if (CE)
        begin
            o_bus_reg <= o_bus_sel;
            o_oe_reg <= (O_SEL != OSEL_NONE);
        end
    end

    assign MICRO_ADDR = micro_address_reg;
    assign PAGE_ADDR = status_page_reg;
    assign STATUS_OUT = status_page_reg;
    assign CARRY_OUT = carry_out_w;
    assign O_BUS_OUT = o_bus_reg;
    assign O_BUS_OE = o_oe_reg;
    assign STACK_FULL = (depth_reg == MPS_DEPTH_FULL);
    assign STACK_TOP = stack_top_w;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    chk_jump_next_field: assert property (CE && INSTR == OP_JUMP_NEXT
        |=> MICRO_ADDR == $past(NEXT_ADDRESS_FIELD))
        else $error("jump did not load next field");
    chk_call_pushes_ret: assert property (CE && INSTR == OP_CALL
        |=> STACK_TOP == $past(addr_inc) && MICRO_ADDR == $past(NEXT_ADDRESS_FIELD))
        else $error("call did not push incremented address");
    chk_repeat_holds_addr: assert property (CE && INSTR == OP_REPEAT_CURRENT && repeat_busy
        |=> $stable(MICRO_ADDR) && repeat_count_reg == dec_one($past(repeat_count_reg)))
        else $error("repeat did not hold address");
    chk_branch_false_inc: assert property (CE && INSTR == OP_COND_BRANCH && !cond
        |=> MICRO_ADDR == $past(addr_inc))
        else $error("false branch did not increment");
    chk_cond_return_pop: assert property (CE && INSTR == OP_COND_RETURN && cond
        |=> MICRO_ADDR == $past(stack_top_w))
        else $error("conditional return did not pop");
    chk_primary_vector: assert property (CE && INSTR == OP_JUMP_PRIMARY
        |=> MICRO_ADDR == $past(instruction_vector_reg))
        else $error("primary jump missed vector");
    chk_status_set_wins: assert property (CE && STATUS_CTL.set_mask != '0
        |=> (STATUS_OUT & $past(STATUS_CTL.set_mask)) == $past(STATUS_CTL.set_mask))
        else $error("status set lost");
    chk_depth_bounded: assert property (depth_reg <= MPS_DEPTH_FULL)
        else $error("stack depth above four");
    chk_freeze_idle: assert property (!CE |=> $stable(MICRO_ADDR) && $stable(depth_reg))
        else $error("state moved while clock enable low");
    chk_full_drops_old: assert property (CE && do_push && STACK_FULL
        |=> STACK_FULL && stack_reg[1] == $past(stack_reg[0]))
        else $error("overflow push misordered stack");

    cov_stack_full: cover property (CE && do_push ##1 STACK_FULL);
    cov_repeat_done: cover property (CE && INSTR == OP_REPEAT_CURRENT && !repeat_busy);
    cov_return: cover property (CE && INSTR == OP_RETURN && depth_reg != '0);
    cov_obus_field: cover property (CE && O_SEL == OSEL_NEXT_FIELD ##1 O_BUS_OE);
endmodule

// [sim/mps_far_side.sv]
`timescale 1ns/1ps
// Condition logic beside the sequencer: one branch line carries the condition
module mps_far_side (
    // Requested condition and the line that carries it
    input wire logic cond,
    input wire logic use_inverted,
    // Branch lines
    output logic branch_cond,
    output logic branch_cond_inverted_n
);
    // The unused line stays inactive, so only one source ever asserts
    assign branch_cond = cond & ~use_inverted;
    assign branch_cond_inverted_n = ~(cond & use_inverted);
endmodule

// [sim/tb_microprogram_sequencer_slice.sv]
`timescale 1ns/1ps
module tb_microprogram_sequencer_slice;
    import mps_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic cin = 1'b1;
    logic cond = 1'b0;
    logic inv = 1'b0;
    logic xpush = 1'b0;
    mps_op_t instr = OP_INCREMENT;
    logic [3:0] nfield = 4'h0;
    logic [3:0] ibus = 4'h0;
    logic [3:0] obin = 4'h0;
    logic [3:0] tin = 4'h0;
    mps_cond_sel_t csel = 3'h0;
    mps_osel_t osel = OSEL_NONE;
    mps_status_ctl_t sctl = 12'h000;
    logic bc, bcn, cout, oe, full;
    logic [3:0] addr, page, obus, stat, top;
    int n_fail = 0;
    int total_checks = 0;

    initial
    begin
        forever #5 clk = ~clk;
    end

    mps_sequencer u_mps_sequencer (.CLOCK(clk), .RST_N(rst_n), .CE(ce), .INSTR(instr),
        .NEXT_ADDRESS_FIELD(nfield), .COND_SEL(csel), .O_SEL(osel), .BRANCH_COND(bc),
        .BRANCH_COND_INVERTED_N(bcn), .CARRY_IN(cin), .CARRY_OUT(cout), .MICRO_ADDR(addr),
        .PAGE_ADDR(page), .I_BUS(ibus), .O_BUS_IN(obin), .O_BUS_OUT(obus), .O_BUS_OE(oe),
        .STATUS_TEST_IN(tin), .STATUS_CTL(sctl), .STATUS_OUT(stat),
        .STACK_EXT_PUSH(xpush), .STACK_FULL(full), .STACK_TOP(top));
    mps_far_side u_mps_far_side (.cond(cond), .use_inverted(inv), .branch_cond(bc),
        .branch_cond_inverted_n(bcn));

    task automatic end_of_test();
        if (n_fail == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Called at a falling edge; returns one falling edge after the taking edge
    task automatic step(input mps_op_t op, input logic [3:0] a);
        instr = op;
        nfield = a;
        @(negedge clk);
    endtask

    task automatic t_call();
        step(OP_JUMP_NEXT, 4'h2);
        step(OP_CALL, 4'h5);
        chk(addr, 4'h5);
        chk(top, 4'h3);
        step(OP_RETURN, 4'h0);
        chk(addr, 4'h3);
    endtask

    // Five nested calls: the oldest return word is dropped, empty pop gives zero
    task automatic t_stack();
        step(OP_JUMP_NEXT, 4'h0);
        for (int i = 1; i <= 5; i++)
            step(OP_CALL, 4'(i));
        chk({3'h0, full}, 4'h1);
        chk(top, 4'h5);
        for (int i = 5; i >= 2; i--)
        begin
            step(OP_RETURN, 4'h0);
            chk(addr, 4'(i));
        end
        chk({3'h0, full}, 4'h0);
        step(OP_RETURN, 4'h0);
        chk(addr, 4'h0);
    endtask

    task automatic t_repeat();
        step(OP_JUMP_NEXT, 4'h6);
        step(OP_REPEAT_SUB_LOAD, 4'h2);
        chk(addr, 4'h7);
        step(OP_REPEAT_CURRENT, 4'h0);
        chk(addr, 4'h7);
        step(OP_REPEAT_CURRENT, 4'h0);
        chk(addr, 4'h7);
        step(OP_REPEAT_CURRENT, 4'h0);
        chk(addr, 4'h8);
        // Saved return word is address plus one, so it counts two repeats here
        step(OP_JUMP_NEXT, 4'h1);
        step(OP_JUMP_NEXT_SAVE_ADDR, 4'he);
        chk(addr, 4'he);
        step(OP_REPEAT_CURRENT, 4'h0);
        chk(addr, 4'he);
        step(OP_REPEAT_CURRENT, 4'h0);
        chk(addr, 4'he);
        step(OP_REPEAT_CURRENT, 4'h0);
        chk(addr, 4'hf);
    endtask

    // Each branch line alone, both levels
    task automatic t_cond();
        for (int k = 0; k < 4; k++)
        begin
            cond = k[0];
            inv = k[1];
            step(OP_JUMP_NEXT, 4'h1);
            step(OP_COND_BRANCH, 4'h9);
            chk(addr, cond ? 4'h9 : 4'h2);
        end
        step(OP_JUMP_NEXT, 4'h3);
        step(OP_COND_CALL, 4'h8);
        chk(addr, 4'h8);
        step(OP_COND_RETURN, 4'hc);
        chk(addr, 4'h4);
        step(OP_MULTIWAY, 4'hc);
        chk(addr, 4'hd);
        cond = 1'b0;
        step(OP_COND_RETURN, 4'hc);
        chk(addr, 4'hc);
        step(OP_COND_CALL, 4'h5);
        chk(addr, 4'hd);
        chk(top, 4'h0);
    endtask

    task automatic t_vector();
        step(OP_JUMP_NEXT_LOAD_VEC, 4'ha);
        step(OP_INCREMENT, 4'h0);
        step(OP_JUMP_PRIMARY, 4'h0);
        chk(addr, 4'ha);
        ibus = 4'h6;
        step(OP_JUMP_IBUS_LOAD_VEC, 4'h0);
        chk(addr, 4'h6);
        step(OP_INCREMENT, 4'h0);
        step(OP_JUMP_PRIMARY, 4'h0);
        chk(addr, 4'h6);
        obin = 4'h9;
        step(OP_JUMP_OBUS, 4'h0);
        chk(addr, 4'h9);
        ibus = 4'h3;
        step(OP_JUMP_IBUS, 4'h0);
        chk(addr, 4'h3);
        step(OP_JUMP_PRIMARY, 4'h0);
        chk(addr, 4'h6);
    endtask

    task automatic t_status();
        osel = OSEL_NEXT_FIELD;
        step(OP_INCREMENT, 4'h5);
        chk(obus, 4'h5);
        chk({3'h0, oe}, 4'h1);
        tin = 4'ha;
        sctl = {4'hf, 4'h0, 4'h0};
        step(OP_INCREMENT, 4'h0);
        chk(stat, 4'ha);
        chk(page, 4'ha);
        sctl = {4'h0, 4'h1, 4'h8};
        step(OP_INCREMENT, 4'h0);
        chk(stat, 4'h3);
        sctl = 12'h000;
        csel = {1'b1, 2'h1};
        step(OP_JUMP_NEXT, 4'h0);
        step(OP_COND_BRANCH, 4'h7);
        chk(addr, 4'h7);
    endtask

    task automatic t_carry();
        step(OP_JUMP_NEXT, 4'hf);
        chk({3'h0, cout}, 4'h1);
        step(OP_INCREMENT, 4'h0);
        chk(addr, 4'h0);
        ce = 1'b0;
        step(OP_JUMP_NEXT, 4'h4);
        chk(addr, 4'h0);
        ce = 1'b1;
        ibus = 4'h7;
        xpush = 1'b1;
        step(OP_INCREMENT, 4'h0);
        xpush = 1'b0;
        chk(top, 4'h7);
        // An upper slice without carry holds its address
        step(OP_JUMP_NEXT, 4'hf);
        cin = 1'b0;
        step(OP_INCREMENT, 4'h0);
        chk(addr, 4'hf);
        chk({3'h0, cout}, 4'h0);
        cin = 1'b1;
    endtask

    task automatic t_obus();
        osel = OSEL_STACK_TOP;
        step(OP_INCREMENT, 4'h0);
        chk(obus, 4'h7);
        osel = OSEL_STATUS;
        step(OP_INCREMENT, 4'h0);
        chk(obus, 4'h3);
        osel = OSEL_NONE;
        step(OP_INCREMENT, 4'h0);
        chk({3'h0, oe}, 4'h0);
    endtask

    // Reset in mid-run empties the stack and clears the status bits
    task automatic t_reset();
        rst_n = 1'b0;
        step(OP_INCREMENT, 4'h0);
        chk(addr, MPS_ADDR_RST);
        chk(stat, MPS_STATUS_RST);
        chk(top, 4'h0);
        chk({2'h0, full, oe}, 4'h0);
        rst_n = 1'b1;
        step(OP_INCREMENT, 4'h0);
        chk(addr, 4'h1);
    endtask

    initial
    begin
        repeat (20) @(negedge clk);
        chk(addr, MPS_ADDR_RST);
        chk(page, MPS_STATUS_RST);
        chk({2'h0, full, oe}, 4'h0);
        rst_n = 1'b1;
        t_call();
        t_stack();
        t_repeat();
        t_cond();
        t_vector();
        t_status();
        t_carry();
        t_obus();
        t_reset();
        end_of_test();
    end

    initial
    begin
        repeat (2000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
endmodule
